//--- verilog/oc_pkg.sv
// ==========================================================================
package oc_pkg;
  // ========================================================================
  // widths and settings
  localparam int          MAG_W          = 16;
  localparam int          STAMP_W        = 32;
  localparam int          GROUP_W        = 3;
  localparam int          GROUPS         = 8;
  localparam logic [15:0] PICKUP_DEFAULT = 16'h0078;
  localparam int          RESET_PCT      = 97;
  localparam int          FULL_PCT       = 100;
  localparam logic [15:0] RATIO_MAX      = 16'hFFFF;
  // ========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAMP_UNIT_NS = 1000000;
  localparam int STAMP_CYCLES  = STAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int PRE_TRIG_MS   = 20;
  localparam int PRE_FAULT_MS  = 200;
  // ========================================================================
  // memories
  localparam int HIST_DEPTH = 256;
  localparam int HIST_AW    = 8;
  localparam int REC_DEPTH  = 12;
  localparam int REC_AW     = 4;
  // ========================================================================
  // types
  typedef logic [2:0][MAG_W-1:0] oc_mag3_t;
  typedef enum logic [1:0] {
    OC_MAG_RMS  = 2'h0,
    OC_MAG_TRMS = 2'h1,
    OC_MAG_PP   = 2'h2
  } oc_mag_sel_t;
  typedef enum logic [2:0] {
    OC_MODE_ON       = 3'h0,
    OC_MODE_BLOCKED  = 3'h1,
    OC_MODE_TEST     = 3'h2,
    OC_MODE_TEST_BLK = 3'h3,
    OC_MODE_OFF      = 3'h4
  } oc_node_mode_t;
  typedef enum logic [3:0] {
    OC_FRC_NORMAL   = 4'h0,
    OC_FRC_START    = 4'h1,
    OC_FRC_TRIP     = 4'h2,
    OC_FRC_BLOCKED  = 4'h3,
    OC_FRC_START_L1 = 4'h4,
    OC_FRC_START_L2 = 4'h5,
    OC_FRC_START_L3 = 4'h6,
    OC_FRC_TRIP_L1  = 4'h7,
    OC_FRC_TRIP_L2  = 4'h8,
    OC_FRC_TRIP_L3  = 4'h9
  } oc_force_t;
  typedef enum logic [1:0] {
    OC_EVT_BOTH = 2'h0,
    OC_EVT_ON   = 2'h1,
    OC_EVT_OFF  = 2'h2
  } oc_evt_filter_t;
  typedef enum logic [1:0] {
    OC_REC_NONE    = 2'h0,
    OC_REC_START   = 2'h1,
    OC_REC_TRIP    = 2'h2,
    OC_REC_BLOCKED = 2'h3
  } oc_rec_kind_t;
  typedef struct packed {
    logic [2:0] trip_ph;
    logic [2:0] start_ph;
    logic       blocked;
    logic       trip;
    logic       start;
  } oc_status_t;
  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    oc_rec_kind_t       kind;
    logic [2:0]         phases;
    logic [MAG_W-1:0]   pre_trig;
    logic [MAG_W-1:0]   fault;
    logic [MAG_W-1:0]   pre_fault;
    logic [15:0]        trip_left;
    logic [GROUP_W-1:0] group;
  } oc_fault_rec_t;
endpackage

//--- verilog/oc_mem.sv
`timescale 1ns/1ps
module oc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // two registered read ports
  input  wire logic [AW-1:0]    rd_a_addr,
  output logic      [WIDTH-1:0] rd_a_data,
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [WIDTH-1:0] rd_b_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem_q[rd_a_addr];
      rd_b_data <= mem_q[rd_b_addr];
    end
  end
endmodule

//--- verilog/oc_stage.sv
`timescale 1ns/1ps
module oc_stage #(
  parameter int unsigned MS_CYCLES = oc_pkg::STAMP_CYCLES
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // measurement chain
  input  wire logic                          proc_tick,
  input  wire oc_pkg::oc_mag3_t              meas_fundamental,
  input  wire oc_pkg::oc_mag3_t              meas_true_rms,
  input  wire oc_pkg::oc_mag3_t              meas_peak_to_peak,
  // blocking matrix and operate-time logic
  input  wire logic                          block_in,
  input  wire logic [2:0]                    trip_req,
  input  wire logic [15:0]                   trip_time_left,
  // general settings
  input  wire oc_pkg::oc_mag_sel_t           mag_sel,
  input  wire logic                          node_mode_allow,
  input  wire oc_pkg::oc_node_mode_t         node_operating_mode,
  input  wire logic                          force_enable,
  input  wire oc_pkg::oc_force_t             forced_status_setting,
  input  wire oc_pkg::oc_evt_filter_t        event_filter,
  // setting groups
  input  wire logic [oc_pkg::GROUP_W-1:0]    active_group,
  input  wire logic                          local_wr,
  input  wire logic [oc_pkg::GROUP_W-1:0]    local_group,
  input  wire logic [15:0]                   local_level,
  input  wire logic                          remote_enable,
  input  wire logic                          remote_wr,
  input  wire logic [15:0]                   remote_level,
  output logic                               remote_refused,
  output logic      [15:0]                   pickup_level,
  // stage status
  output oc_pkg::oc_status_t                 status,
  output oc_pkg::oc_mag3_t                   ratio,
  output logic                               test_mode,
  // events
  output logic                               event_valid,
  output logic      [8:0]                    event_on,
  output logic      [8:0]                    event_off,
  output logic      [oc_pkg::STAMP_W-1:0]    event_stamp,
  // counters
  input  wire logic [2:0]                    cnt_clr,
  output logic      [15:0]                   start_count,
  output logic      [15:0]                   trip_count,
  output logic      [15:0]                   block_count,
  // fault records
  input  wire logic [oc_pkg::REC_AW-1:0]     rec_index,
  output oc_pkg::oc_fault_rec_t              rec_data,
  output logic      [oc_pkg::REC_AW-1:0]     rec_count,
  output logic      [oc_pkg::STAMP_W-1:0]    time_stamp
);
  // ========================================================================
  // functions
  function automatic oc_pkg::oc_mag3_t sel_mag(input oc_pkg::oc_mag_sel_t s, input oc_pkg::oc_mag3_t f,
                                               input oc_pkg::oc_mag3_t t, input oc_pkg::oc_mag3_t p);
    case (s)
      oc_pkg::OC_MAG_TRMS: sel_mag = t;
      oc_pkg::OC_MAG_PP:   sel_mag = p;
      default:             sel_mag = f;
    endcase
  endfunction

  function automatic logic [15:0] max3(input oc_pkg::oc_mag3_t m);
    logic [15:0] r;
    r = (m[0] > m[1]) ? m[0] : m[1];
    max3 = (m[2] > r) ? m[2] : r;
  endfunction

  function automatic logic [15:0] ratio_of(input logic [15:0] m, input logic [15:0] lvl);
    logic [31:0] q;
    q = '0;
    if (lvl != 16'h0000) begin
      q = (32'(m) * 32'(oc_pkg::FULL_PCT)) / 32'(lvl);
    end
    ratio_of = (lvl == 16'h0000 || q > 32'(oc_pkg::RATIO_MAX)) ? oc_pkg::RATIO_MAX : q[15:0];
  endfunction

  function automatic logic below_reset(input logic [15:0] m, input logic [15:0] lvl);
    below_reset = (32'(m) * 32'(oc_pkg::FULL_PCT)) < (32'(lvl) * 32'(oc_pkg::RESET_PCT));
  endfunction

  // ========================================================================
  // time base
  logic [31:0]                 ms_div_q;
  logic                        ms_tick;
  logic [oc_pkg::STAMP_W-1:0]  stamp_q;

  assign ms_tick    = (ms_div_q == 32'(MS_CYCLES - 1));
  assign time_stamp = stamp_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_div_q <= '0;
      stamp_q  <= '0;
    end else if (ms_tick) begin
      ms_div_q <= '0;
      stamp_q  <= stamp_q + 1'b1;
    end else begin
      ms_div_q <= ms_div_q + 1'b1;
    end
  end

  // ========================================================================
  // pick-up level per setting group
  logic [15:0] pickup_q [oc_pkg::GROUPS];
  logic        remote_refused_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int g = 0; g < oc_pkg::GROUPS; g++) begin
        pickup_q[g] <= oc_pkg::PICKUP_DEFAULT;
      end
      remote_refused_q <= 1'b0;
    end else begin
      remote_refused_q <= remote_wr && !remote_enable;
      if (local_wr) begin
        pickup_q[local_group] <= local_level;
      end
      // remote write lands last so it wins a same-cycle collision
      if (remote_wr && remote_enable) begin
        pickup_q[active_group] <= remote_level;
      end
    end
  end

  // group switch takes effect on the next comparison, no restart
  assign pickup_level   = pickup_q[active_group];
  assign remote_refused = remote_refused_q;

  // ========================================================================
  // comparison and status
  oc_pkg::oc_mag3_t       mag;
  oc_pkg::oc_node_mode_t  mode;
  logic [2:0]             pick_q;
  logic [2:0]             pick_d;
  logic                   eff_block;
  oc_pkg::oc_status_t     status_q;
  oc_pkg::oc_status_t     status_d;
  oc_pkg::oc_mag3_t       ratio_q;

  // general settings come straight from static inputs, never from a group
  assign mag  = sel_mag(mag_sel, meas_fundamental, meas_true_rms, meas_peak_to_peak);
  assign mode = node_mode_allow ? node_operating_mode : oc_pkg::OC_MODE_ON;
  assign eff_block = block_in || mode == oc_pkg::OC_MODE_BLOCKED || mode == oc_pkg::OC_MODE_TEST_BLK;
  assign test_mode = mode == oc_pkg::OC_MODE_TEST || mode == oc_pkg::OC_MODE_TEST_BLK;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (mag[p] > pickup_level) begin
        pick_d[p] = 1'b1;
      end else if (below_reset(mag[p], pickup_level)) begin
        pick_d[p] = 1'b0;
      end else begin
        pick_d[p] = pick_q[p];
      end
    end
  end

  always_comb begin
    status_d          = '0;
    status_d.start_ph = eff_block ? 3'h0 : pick_d;
    status_d.trip_ph  = status_d.start_ph & trip_req;
    status_d.blocked  = eff_block && (|pick_d);
    if (force_enable) begin
      status_d = '0;
      case (forced_status_setting)
        oc_pkg::OC_FRC_START:    status_d.start_ph = 3'h7;
        oc_pkg::OC_FRC_TRIP:     begin
          status_d.start_ph = 3'h7;
          status_d.trip_ph  = 3'h7;
        end
        oc_pkg::OC_FRC_BLOCKED:  status_d.blocked = 1'b1;
        oc_pkg::OC_FRC_START_L1: status_d.start_ph = 3'h1;
        oc_pkg::OC_FRC_START_L2: status_d.start_ph = 3'h2;
        oc_pkg::OC_FRC_START_L3: status_d.start_ph = 3'h4;
        oc_pkg::OC_FRC_TRIP_L1:  begin
          status_d.start_ph = 3'h1;
          status_d.trip_ph  = 3'h1;
        end
        oc_pkg::OC_FRC_TRIP_L2:  begin
          status_d.start_ph = 3'h2;
          status_d.trip_ph  = 3'h2;
        end
        oc_pkg::OC_FRC_TRIP_L3:  begin
          status_d.start_ph = 3'h4;
          status_d.trip_ph  = 3'h4;
        end
        default:                 status_d = '0;
      endcase
    end
    if (mode == oc_pkg::OC_MODE_OFF) begin
      status_d = '0;
    end
    status_d.start = |status_d.start_ph;
    status_d.trip  = |status_d.trip_ph;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pick_q   <= '0;
      status_q <= '0;
      ratio_q  <= '0;
    end else if (proc_tick) begin
      pick_q   <= (mode == oc_pkg::OC_MODE_OFF) ? 3'h0 : pick_d;
      status_q <= status_d;
      for (int p = 0; p < 3; p++) begin
        ratio_q[p] <= ratio_of(mag[p], pickup_level);
      end
    end
  end

  assign status = status_q;
  assign ratio  = ratio_q;

  // ========================================================================
  // events
  logic [8:0]                 rise;
  logic [8:0]                 fall;
  logic [8:0]                 on_q;
  logic [8:0]                 off_q;
  logic                       evt_valid_q;
  logic [oc_pkg::STAMP_W-1:0] evt_stamp_q;

  assign rise = proc_tick ? (status_d & ~status_q) : 9'h000;
  assign fall = proc_tick ? (~status_d & status_q) : 9'h000;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_q        <= '0;
      off_q       <= '0;
      evt_valid_q <= 1'b0;
      evt_stamp_q <= '0;
    end else begin
      on_q        <= (event_filter == oc_pkg::OC_EVT_OFF) ? 9'h000 : rise;
      off_q       <= (event_filter == oc_pkg::OC_EVT_ON) ? 9'h000 : fall;
      evt_valid_q <= ((event_filter != oc_pkg::OC_EVT_OFF) && (|rise)) ||
                     ((event_filter != oc_pkg::OC_EVT_ON) && (|fall));
      if (|(rise | fall)) begin
        evt_stamp_q <= stamp_q;
      end
    end
  end

  assign event_on    = on_q;
  assign event_off   = off_q;
  assign event_valid = evt_valid_q;
  assign event_stamp = evt_stamp_q;

  // ========================================================================
  // cumulative counters, a clear beats a same-cycle count
  logic [15:0] start_cnt_q;
  logic [15:0] trip_cnt_q;
  logic [15:0] block_cnt_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_cnt_q <= '0;
      trip_cnt_q  <= '0;
      block_cnt_q <= '0;
    end else begin
      start_cnt_q <= cnt_clr[0] ? 16'h0000 : start_cnt_q + 16'(rise[0]);
      trip_cnt_q  <= cnt_clr[1] ? 16'h0000 : trip_cnt_q + 16'(rise[1]);
      block_cnt_q <= cnt_clr[2] ? 16'h0000 : block_cnt_q + 16'(rise[2]);
    end
  end

  assign start_count = start_cnt_q;
  assign trip_count  = trip_cnt_q;
  assign block_count = block_cnt_q;

  // ========================================================================
  // current history, one sample of the highest phase per millisecond
  logic [oc_pkg::HIST_AW-1:0] hist_wp_q;
  logic [7:0]                 hist_age_q;
  logic [15:0]                pre_trig_raw;
  logic [15:0]                pre_fault_raw;
  logic [15:0]                pre_trig;
  logic [15:0]                pre_fault;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hist_wp_q  <= '0;
      hist_age_q <= '0;
    end else if (ms_tick) begin
      hist_wp_q <= hist_wp_q + 1'b1;
      if (hist_age_q != 8'hFF) begin
        hist_age_q <= hist_age_q + 1'b1;
      end
    end
  end

  oc_mem #(.WIDTH(16), .DEPTH(oc_pkg::HIST_DEPTH), .AW(oc_pkg::HIST_AW)) u_hist (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (ms_tick),
    .wr_addr   (hist_wp_q),
    .wr_data   (max3(mag)),
    .rd_a_addr (hist_wp_q - 8'(oc_pkg::PRE_TRIG_MS)),
    .rd_a_data (pre_trig_raw),
    .rd_b_addr (hist_wp_q - 8'(oc_pkg::PRE_FAULT_MS)),
    .rd_b_data (pre_fault_raw)
  );

  // unwritten history slots report zero instead of stale contents
  assign pre_trig  = (hist_age_q > 8'(oc_pkg::PRE_TRIG_MS)) ? pre_trig_raw : 16'h0000;
  assign pre_fault = (hist_age_q > 8'(oc_pkg::PRE_FAULT_MS)) ? pre_fault_raw : 16'h0000;

  // ========================================================================
  // fault records
  logic [oc_pkg::REC_AW-1:0] rec_wp_q;
  logic [oc_pkg::REC_AW-1:0] rec_cnt_q;
  logic [oc_pkg::REC_AW-1:0] rec_rd_addr;
  logic                      rec_we;
  oc_pkg::oc_fault_rec_t     rec_new;

  assign rec_we = |rise[2:0];

  always_comb begin
    rec_new           = '0;
    rec_new.stamp     = stamp_q;
    rec_new.kind      = rise[1] ? oc_pkg::OC_REC_TRIP :
                        rise[0] ? oc_pkg::OC_REC_START : oc_pkg::OC_REC_BLOCKED;
    rec_new.phases    = pick_d;
    rec_new.pre_trig  = pre_trig;
    rec_new.fault     = max3(mag);
    rec_new.pre_fault = pre_fault;
    rec_new.trip_left = trip_time_left;
    rec_new.group     = active_group;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_wp_q  <= '0;
      rec_cnt_q <= '0;
    end else if (rec_we) begin
      // wrap overwrites the oldest entry
      rec_wp_q <= (rec_wp_q == 4'(oc_pkg::REC_DEPTH - 1)) ? 4'h0 : rec_wp_q + 1'b1;
      if (rec_cnt_q != 4'(oc_pkg::REC_DEPTH)) begin
        rec_cnt_q <= rec_cnt_q + 1'b1;
      end
    end
  end

  // index 0 is the newest record
  always_comb begin
    logic [4:0] a;
    a = 5'(rec_wp_q) + 5'(oc_pkg::REC_DEPTH) - 5'd1 - 5'(rec_index);
    if (a >= 5'(oc_pkg::REC_DEPTH)) begin
      a = a - 5'(oc_pkg::REC_DEPTH);
    end
    rec_rd_addr = a[3:0];
  end

  oc_mem #(.WIDTH($bits(oc_pkg::oc_fault_rec_t)), .DEPTH(oc_pkg::REC_DEPTH), .AW(oc_pkg::REC_AW)) u_rec (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (rec_we),
    .wr_addr   (rec_wp_q),
    .wr_data   (rec_new),
    .rd_a_addr (rec_rd_addr),
    .rd_a_data (rec_data),
    .rd_b_addr (4'h0),
    .rd_b_data ()
  );

  assign rec_count = rec_cnt_q;

  // ========================================================================
  // assertions
  start_on_evt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rise[0] && event_filter != oc_pkg::OC_EVT_OFF) |=> (event_on[0] && event_valid && status.start))
    else $error("start rise gave no ON event");
  filter_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $past(event_filter) == oc_pkg::OC_EVT_ON |-> event_off == 9'h000)
    else $error("OFF event passed an ON-only filter");
  evt_stamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (|(rise | fall)) |=> event_stamp == $past(stamp_q))
    else $error("event stamp differs from change time");
  trip_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rise[1] && !cnt_clr[1]) |=> trip_count == $past(trip_count) + 16'h0001)
    else $error("trip counter missed an occurrence");
  rec_depth_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rec_count <= 4'(oc_pkg::REC_DEPTH) && rec_wp_q < 4'(oc_pkg::REC_DEPTH))
    else $error("record store exceeds twelve");
  rec_only_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rec_count != $past(rec_count)) |-> $past(status_d.start && !status.start ||
      status_d.trip && !status.trip || status_d.blocked && !status.blocked) && $past(proc_tick))
    else $error("record written without an ON transition");
  pick_rise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (proc_tick && mode != oc_pkg::OC_MODE_OFF && mag[0] > pickup_level) |=> pick_q[0])
    else $error("phase A missed pick-up");
  hyst_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (proc_tick && pick_q[1] && mode != oc_pkg::OC_MODE_OFF && !below_reset(mag[1], pickup_level)) |=> pick_q[1])
    else $error("phase B released above reset ratio");
  remote_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (remote_wr && !remote_enable) |=> (remote_refused && pickup_q[$past(active_group)] ==
      ($past(local_wr) && $past(local_group) == $past(active_group) ? $past(local_level) : $past(pickup_level))))
    else $error("remote change taken while disabled");
  block_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (proc_tick && block_in && !force_enable) |=> (status.start_ph == 3'h0))
    else $error("start raised under block");
endmodule

//--- tb/oc_meas_model.sv
`timescale 1ns/1ps
module oc_meas_model (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // wanted values
  input  wire oc_pkg::oc_mag3_t mag_want,
  input  wire logic             blk_want,
  // towards the stage
  output logic                  proc_tick,
  output oc_pkg::oc_mag3_t      meas_fundamental,
  output logic                  block_in
);
  logic [1:0] div_q;
  // ==========
  // chain: new values land on every falling edge; a processing tick comes every fourth clock
  always_ff @(negedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 2'h0;
      proc_tick <= 1'b0;
      meas_fundamental <= '0;
      block_in <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      proc_tick <= (div_q == 2'h3);
      meas_fundamental <= mag_want;
      block_in <= blk_want;
    end
  end
endmodule

//--- tb/tb_overcurrent_stage_event_recorder.sv
`timescale 1ns/1ps
module tb_overcurrent_stage_event_recorder;
  logic             sys_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             blk_want = 1'b0;
  logic             remote_wr = 1'b0;
  logic             remote_en = 1'b0;
  logic [15:0]      rlvl = 16'h0000;
  logic [2:0]       cnt_clr = 3'h0;
  logic [2:0]       trip_req = 3'h0;
  logic [2:0]       grp = 3'h0;
  logic [3:0]       rec_idx = 4'h0;
  logic             mode_allow = 1'b0;
  logic             force_en = 1'b0;
  oc_pkg::oc_mag_sel_t    mag_sel = oc_pkg::OC_MAG_RMS;
  oc_pkg::oc_node_mode_t  node_mode = oc_pkg::OC_MODE_ON;
  oc_pkg::oc_force_t      force_sel = oc_pkg::OC_FRC_NORMAL;
  oc_pkg::oc_evt_filter_t evt_flt = oc_pkg::OC_EVT_BOTH;
  oc_pkg::oc_fault_rec_t  rec;
  oc_pkg::oc_mag3_t       rat;
  logic             refused, tmode;
  logic [3:0]       rcnt;
  logic [31:0]      rnd = 32'd48;
  oc_pkg::oc_mag3_t mag_want = '0;
  oc_pkg::oc_mag3_t meas;
  oc_pkg::oc_status_t status;
  logic             tick, blk, ev_v;
  logic [8:0]       ev_on, ev_off;
  logic [15:0]      lvl, scnt, tcnt, bcnt;
  logic [17:0]      expq[$];
  int               fails = 0;
  int               checked = 0;
  // ==========
  // clock, partner, design
  initial forever #20 sys_clk = ~sys_clk;
  oc_meas_model mdl_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .mag_want(mag_want), .blk_want(blk_want),
    .proc_tick(tick), .meas_fundamental(meas), .block_in(blk));
  // random true-rms values must be ignored; peak values stay far above the group 0 level
  oc_stage #(.MS_CYCLES(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .proc_tick(tick),
    .meas_fundamental(meas), .meas_true_rms({3{rnd[15:0]}}), .meas_peak_to_peak({3{rnd[31:16] | 16'h8000}}),
    .block_in(blk), .trip_req(trip_req), .trip_time_left(16'h0000), .mag_sel(mag_sel),
    .node_mode_allow(mode_allow), .node_operating_mode(node_mode), .force_enable(force_en),
    .forced_status_setting(force_sel), .event_filter(evt_flt),
    .active_group(grp), .local_wr(1'b0), .local_group(3'h0), .local_level(16'h0000),
    .remote_enable(remote_en), .remote_wr(remote_wr), .remote_level(rlvl), .remote_refused(refused),
    .pickup_level(lvl), .status(status), .ratio(rat), .test_mode(tmode), .event_valid(ev_v), .event_on(ev_on),
    .event_off(ev_off), .event_stamp(), .cnt_clr(cnt_clr), .start_count(scnt), .trip_count(tcnt),
    .block_count(bcnt), .rec_index(rec_idx), .rec_data(rec), .rec_count(rcnt), .time_stamp());
  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk iff tick === 1'b1);
    @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) rnd <= xs(rnd);
  // ==========
  // monitor: every event must match the oldest note
  always @(negedge sys_clk) begin
    if (ev_v === 1'b1) begin
      if (expq.size() == 0) chk(18'h3FFFF, 18'h00000);
      else chk({ev_on, ev_off}, expq.pop_front());
    end
  end
  // ==========
  // scenarios
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk({2'h0, lvl}, 18'h00078);
    remote_wr = 1'b1;
    @(negedge sys_clk);
    chk({17'h00000, refused}, 18'h00001);
    remote_wr = 1'b0;
    @(negedge sys_clk);
    chk({2'h0, lvl}, 18'h00078);
    // random level taken while enabled, into group 1 only
    grp = 3'h1;
    remote_en = 1'b1;
    rlvl = rnd[15:0] | 16'h0100;
    remote_wr = 1'b1;
    @(negedge sys_clk);
    remote_wr = 1'b0;
    remote_en = 1'b0;
    chk({2'h0, lvl}, {2'h0, rlvl});
    grp = 3'h0;
    @(negedge sys_clk);
    chk({2'h0, lvl}, 18'h00078);
    mag_want[0] = 16'h0079;
    expq.push_back({9'h009, 9'h000});
    ticks(2);
    chk({9'h000, status}, 18'h00009);
    chk({2'h0, scnt}, 18'h00001);
    chk({2'h0, rat[0]}, 18'h00064);
    trip_req = 3'h1;
    expq.push_back({9'h042, 9'h000});
    ticks(2);
    chk({9'h000, status}, 18'h0004B);
    chk({2'h0, tcnt}, 18'h00001);
    chk(18'(rec.kind), 18'(oc_pkg::OC_REC_TRIP));
    chk({15'h0000, rec.phases}, 18'h00001);
    chk({2'h0, rec.fault}, 18'h00079);
    rec_idx = 4'h1;
    @(negedge sys_clk);
    chk(18'(rec.kind), 18'(oc_pkg::OC_REC_START));
    rec_idx = 4'h0;
    // trip release is an OFF event, hidden by the ON-only filter
    trip_req = 3'h0;
    evt_flt = oc_pkg::OC_EVT_ON;
    ticks(2);
    chk({9'h000, status}, 18'h00009);
    evt_flt = oc_pkg::OC_EVT_BOTH;
    // 117 is still at or above 97 percent of 120
    mag_want[0] = 16'h0075;
    ticks(2);
    chk({9'h000, status}, 18'h00009);
    mag_want[0] = 16'h0074;
    expq.push_back({9'h000, 9'h009});
    ticks(2);
    mag_sel = oc_pkg::OC_MAG_PP;
    expq.push_back({9'h039, 9'h000});
    ticks(2);
    chk({9'h000, status}, 18'h00039);
    mag_sel = oc_pkg::OC_MAG_RMS;
    expq.push_back({9'h000, 9'h039});
    ticks(2);
    blk_want = 1'b1;
    mag_want[1] = 16'h0079;
    expq.push_back({9'h004, 9'h000});
    ticks(2);
    chk({9'h000, status}, 18'h00004);
    chk({2'h0, bcnt}, 18'h00001);
    force_en = 1'b1;
    force_sel = oc_pkg::OC_FRC_TRIP_L2;
    expq.push_back({9'h093, 9'h004});
    ticks(2);
    chk({9'h000, status}, 18'h00093);
    force_en = 1'b0;
    mode_allow = 1'b1;
    node_mode = oc_pkg::OC_MODE_OFF;
    expq.push_back({9'h000, 9'h093});
    ticks(2);
    chk({9'h000, status}, 18'h00000);
    node_mode = oc_pkg::OC_MODE_TEST;
    expq.push_back({9'h004, 9'h000});
    ticks(2);
    chk({17'h00000, tmode}, 18'h00001);
    chk({14'h0000, rcnt}, 18'h00006);
    cnt_clr = 3'h1;
    @(negedge sys_clk);
    cnt_clr = 3'h0;
    @(negedge sys_clk);
    chk({2'h0, scnt}, 18'h00000);
    chk(18'(expq.size()), 18'h00000);
    finish_test();
  end
  // whole run is near 110 cycles; 750 allowed
  initial begin
    #30us;
    fails++;
    finish_test();
  end
endmodule
